// ==== src/rwd_top.sv ====
`timescale 1ns/1ps
module rwd_top #(
	parameter int DELAY_BASE_CYC = rwd_pkg::TOUT_BASE_CYC,
	parameter int DLY_W = 24,
	parameter int WDT_BASE = rwd_pkg::WDT_BASE_OSC,
	parameter int WDT_W = 21
) (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic POR_LOW_I,
	input wire logic RESET_PIN_N_I,
	input wire logic BOD_LOW_I,
	input wire logic BOD_ENABLE_I,
	input wire logic TEST_RESET_I,
	input wire logic RESET_PIN_DISABLE_FUSE_I,
	input wire logic WATCHDOG_ALWAYS_ON_FUSE_I,
	input wire logic [1:0] STARTUP_TIME_FUSE_I,
	input wire logic [3:0] CLOCK_SOURCE_FUSE_I,
	input wire logic WDT_OSC_I,
	input wire logic WDT_RESTART_I,
	input wire logic WDT_IRQ_ACK_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	output logic IO_RESET_N_O,
	output logic SYS_RESET_N_O,
	output logic WDT_IRQ_O,
	output logic WDT_RESET_PULSE_O
);
	import rwd_pkg::*;

	// ****************************************************
	// input synchronisers
	// ****************************************************
	logic [13:0] sync_q;
	wire [13:0] sync_d = {CLOCK_SOURCE_FUSE_I, STARTUP_TIME_FUSE_I, WDT_OSC_I,
		WATCHDOG_ALWAYS_ON_FUSE_I, RESET_PIN_DISABLE_FUSE_I, TEST_RESET_I,
		BOD_ENABLE_I, BOD_LOW_I, RESET_PIN_N_I, POR_LOW_I};

	rwd_sync #(.W(14), .RST_VAL(14'h0002)) u_sync (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.d_i(sync_d),
		.q_o(sync_q)
	);
	wire por_s, pin_n_s, bod_s, bod_en_s, test_s, pin_dis_s, aon_s, osc_s;
	wire [1:0] sut_s;
	wire [3:0] cks_s;
	assign {cks_s, sut_s, osc_s, aon_s, pin_dis_s, test_s, bod_en_s, bod_s, pin_n_s,
		por_s} = sync_q;
	// ****************************************************
	// reset sources
	// ****************************************************
	logic wdt_pulse_ff;
	wire src_por = por_s;
	wire src_ext = !pin_n_s && !pin_dis_s;
	wire src_bod = bod_s && bod_en_s;
	wire src_test = test_s;
	wire src_pins = src_por || src_ext || src_bod || src_test;
	wire src_any = src_pins || wdt_pulse_ff;
	// raw path: ports clear even with the clock stopped
	assign IO_RESET_N_O = !(POR_LOW_I || TEST_RESET_I || wdt_pulse_ff
		|| (!RESET_PIN_N_I && !RESET_PIN_DISABLE_FUSE_I)
		|| (BOD_LOW_I && BOD_ENABLE_I));
	// ****************************************************
	// reset stretch sequencer
	// ****************************************************
	rwd_rst_state_t state_ff, nxt_state;
	logic [DLY_W-1:0] dly_cnt_ff, nxt_dly_cnt;
	logic sys_rst_n_ff;
	wire [2:0] dly_shift = {1'b0, sut_s} + {2'b00, cks_s[0]};
	wire [DLY_W-1:0] dly_target = DLY_W'(DELAY_BASE_CYC) << dly_shift;
	wire in_rst = !sys_rst_n_ff;
	always_comb begin
		nxt_state = state_ff;
		nxt_dly_cnt = dly_cnt_ff;
		case (state_ff)
			RS_HOLD: begin
				nxt_dly_cnt = '0;
				if (!src_any) begin
					nxt_state = RS_DELAY;
				end
			end
			RS_DELAY: begin
				if (src_any) begin
					nxt_state = RS_HOLD;
					nxt_dly_cnt = '0;
				end else if (dly_cnt_ff + 1'b1 >= dly_target) begin
					nxt_state = RS_RUN;
				end else begin
					nxt_dly_cnt = dly_cnt_ff + 1'b1;
				end
			end
			RS_RUN: begin
				if (src_any) begin
					nxt_state = RS_HOLD;
				end
			end
			default: nxt_state = RS_HOLD;
		endcase
	end
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			state_ff <= RS_HOLD;
			dly_cnt_ff <= '0;
			sys_rst_n_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			dly_cnt_ff <= nxt_dly_cnt;
			sys_rst_n_ff <= (nxt_state == RS_RUN);
		end
	end
	assign SYS_RESET_N_O = sys_rst_n_ff;
	// ****************************************************
	// bus slave
	// ****************************************************
	logic [11:0] ap_addr_ff;
	logic wr_ph_ff;
	logic rd_wait_ff;
	logic [31:0] hrdata_ff;
	logic [CAUSE_W-1:0] cause_ff, nxt_cause;
	logic wde_ff, watchdog_interrupt_enable_ff, watchdog_interrupt_flag_ff, watchdog_change_enable_ff;
	logic [3:0] wdp_ff;
	logic [2:0] win_cnt_ff;
	wire take = HSEL_I && HTRANS_I[1] && HREADY_I;
	wire sel_cause = (ap_addr_ff == ADDR_RESET_CAUSE);
	wire sel_ctrl = (ap_addr_ff == ADDR_WDT_CTRL);
	wire wr_cause = wr_ph_ff && sel_cause;
	wire wr_ctrl = wr_ph_ff && sel_ctrl;
	wire [7:0] wd = HWDATA_I[7:0];
	wire eff_wde = wde_ff || cause_ff[CAUSE_WDT] || aon_s;
	wire eff_watchdog_interrupt_enable = watchdog_interrupt_enable_ff && !aon_s;
	wire [7:0] ctrl_view = {watchdog_interrupt_flag_ff, eff_watchdog_interrupt_enable, wdp_ff[3], watchdog_change_enable_ff, eff_wde, wdp_ff[2:0]};
	wire [31:0] rd_val = sel_cause ? {27'h0, cause_ff} :
		sel_ctrl ? {24'h0, ctrl_view} : 32'h0;
	// reads take one wait state so a write just before is seen
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			ap_addr_ff <= 12'h000;
			wr_ph_ff <= 1'b0;
			rd_wait_ff <= 1'b0;
			hrdata_ff <= 32'h0;
		end else begin
			if (HREADY_I) begin
				ap_addr_ff <= HADDR_I[11:0];
				wr_ph_ff <= take && HWRITE_I;
			end
			rd_wait_ff <= take && !HWRITE_I;
			if (rd_wait_ff) begin
				hrdata_ff <= rd_val;
			end
		end
	end
	assign HREADYOUT_O = !rd_wait_ff;
	assign HRESP_O = 1'b0;
	assign HRDATA_O = hrdata_ff;
	// ****************************************************
	// watchdog control register
	// ****************************************************
	logic [WDT_W-1:0] wdt_cnt_ff;
	logic osc_d_ff;
	wire wdt_run = eff_wde || eff_watchdog_interrupt_enable;
	wire tick = osc_s && !osc_d_ff;
	wire [3:0] ps_eff = (wdp_ff > WDT_PS_MAX) ? WDT_PS_MAX : wdp_ff;
	wire [WDT_W:0] wdt_limit = (WDT_W + 1)'(WDT_BASE) << ps_eff;
	wire wdt_hit = tick && wdt_run && ({1'b0, wdt_cnt_ff} == wdt_limit - (WDT_W + 1)'(1));
	wire expire = wdt_hit && !WDT_RESTART_I && !in_rst;
	wire irq_expire = expire && eff_watchdog_interrupt_enable;
	wire rst_expire = expire && eff_wde && !eff_watchdog_interrupt_enable;
	wire ack = WDT_IRQ_ACK_I && !in_rst;
	// unlock needs both bits in one write; ignored while already open
	wire unlock = wr_ctrl && wd[CTRL_CE] && wd[CTRL_RE] && !watchdog_change_enable_ff;
	wire change = wr_ctrl && watchdog_change_enable_ff && !wd[CTRL_CE];
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I || in_rst) begin
			wde_ff <= CTRL_RST[CTRL_RE];
			watchdog_interrupt_enable_ff <= CTRL_RST[CTRL_IE];
			watchdog_interrupt_flag_ff <= CTRL_RST[CTRL_IF];
			watchdog_change_enable_ff <= CTRL_RST[CTRL_CE];
			wdp_ff <= {CTRL_RST[CTRL_PS3], CTRL_RST[CTRL_PS_LO+2:CTRL_PS_LO]};
			win_cnt_ff <= 3'h0;
		end else begin
			if (change) begin
				wde_ff <= wd[CTRL_RE] || cause_ff[CAUSE_WDT] || aon_s;
				wdp_ff <= {wd[CTRL_PS3], wd[CTRL_PS_LO+2:CTRL_PS_LO]};
			end else if (wr_ctrl && wd[CTRL_RE]) begin
				wde_ff <= 1'b1;
			end
			if ((irq_expire || ack) && eff_wde) begin
				watchdog_interrupt_enable_ff <= 1'b0;
			end else if (wr_ctrl) begin
				watchdog_interrupt_enable_ff <= wd[CTRL_IE];
			end
			if (irq_expire) begin
				watchdog_interrupt_flag_ff <= 1'b1;
			end else if (ack || (wr_ctrl && wd[CTRL_IF])) begin
				watchdog_interrupt_flag_ff <= 1'b0;
			end
			if (unlock) begin
				watchdog_change_enable_ff <= 1'b1;
				win_cnt_ff <= WINDOW_LOAD;
			end else if (change || (watchdog_change_enable_ff && win_cnt_ff == 3'h1)) begin
				watchdog_change_enable_ff <= 1'b0;
				win_cnt_ff <= 3'h0;
			end else if (win_cnt_ff != 3'h0) begin
				win_cnt_ff <= win_cnt_ff - 3'h1;
			end
		end
	end

	// ****************************************************
	// watchdog counter
	// ****************************************************
	// no sleep input: counting never pauses once enabled
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			osc_d_ff <= 1'b0;
			wdt_cnt_ff <= '0;
			wdt_pulse_ff <= 1'b0;
		end else begin
			osc_d_ff <= osc_s;
			wdt_pulse_ff <= rst_expire;
			if (in_rst || WDT_RESTART_I || !wdt_run || wdt_hit) begin
				wdt_cnt_ff <= '0;
			end else if (tick) begin
				wdt_cnt_ff <= wdt_cnt_ff + 1'b1;
			end
		end
	end

	assign WDT_IRQ_O = watchdog_interrupt_flag_ff;
	assign WDT_RESET_PULSE_O = wdt_pulse_ff;

	// ****************************************************
	// reset cause flags
	// ****************************************************
	always_comb begin
		nxt_cause = cause_ff & (wr_cause ? wd[CAUSE_W-1:0] : {CAUSE_W{1'b1}});
		// hardware set wins over a software clear in the same cycle
		nxt_cause[CAUSE_EXT] = nxt_cause[CAUSE_EXT] || src_ext;
		nxt_cause[CAUSE_BOD] = nxt_cause[CAUSE_BOD] || src_bod;
		nxt_cause[CAUSE_WDT] = nxt_cause[CAUSE_WDT] || wdt_pulse_ff;
		nxt_cause[CAUSE_TEST] = nxt_cause[CAUSE_TEST] || src_test;
		if (src_por) begin
			nxt_cause = '0;
			nxt_cause[CAUSE_POR] = 1'b1;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			cause_ff <= CAUSE_RST;
		end else begin
			cause_ff <= nxt_cause;
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);

	a_pulse_one_clk: assert property (wdt_pulse_ff |=> !wdt_pulse_ff)
		else $error("watchdog reset pulse longer than one clock");
	a_delay_after_pulse: assert property ($fell(wdt_pulse_ff) && !src_pins
		|=> state_ff == RS_DELAY && dly_cnt_ff == '0 && !sys_rst_n_ff)
		else $error("delay did not start after watchdog pulse");
	a_source_holds: assert property (src_any |=> !sys_rst_n_ff ##1 !sys_rst_n_ff)
		else $error("active source did not hold internal reset");
	a_restart_delay: assert property (state_ff == RS_DELAY && src_any
		|=> state_ff == RS_HOLD && dly_cnt_ff == '0)
		else $error("delay not restarted by source");
	a_io_reset_raw: assert property (POR_LOW_I || TEST_RESET_I |-> !IO_RESET_N_O)
		else $error("io reset not asserted by raw source");
	a_ext_resets: assert property (src_ext && !src_por
		|=> !sys_rst_n_ff && cause_ff[CAUSE_EXT])
		else $error("external reset not taken");
	a_window_closes: assert property ($rose(watchdog_change_enable_ff) |-> ##4 !watchdog_change_enable_ff)
		else $error("change enable did not clear after four clocks");
	a_fuse_locks: assert property (aon_s |-> ctrl_view[CTRL_RE] && !ctrl_view[CTRL_IE])
		else $error("always-on fuse did not lock mode bits");
	a_flag_forces_wde: assert property (cause_ff[CAUSE_WDT] && change && !in_rst
		|=> wde_ff)
		else $error("reset-enable cleared while watchdog flag set");
	a_restart_clears: assert property (WDT_RESTART_I |=> wdt_cnt_ff == '0)
		else $error("restart did not clear watchdog counter");
	a_irq_mode: assert property (irq_expire && !eff_wde
		|=> watchdog_interrupt_flag_ff && WDT_IRQ_O && !wdt_pulse_ff)
		else $error("interrupt mode expiry wrong");
	a_combined_mode: assert property (irq_expire && eff_wde
		|=> watchdog_interrupt_flag_ff && !watchdog_interrupt_enable_ff && !wdt_pulse_ff)
		else $error("combined mode did not move to reset mode");
	a_por_clears: assert property (src_por |=> cause_ff == CAUSE_W'(1))
		else $error("power-on did not clear other flags");

	c_wdt_reset: cover property (wdt_pulse_ff ##1 state_ff == RS_HOLD);
	c_wdt_irq: cover property ($rose(watchdog_interrupt_flag_ff));
	c_unlock_clear: cover property (unlock ##[1:4] change && !wd[CTRL_RE]);
	c_reset_release: cover property ($rose(sys_rst_n_ff));
endmodule // rwd_top

// ==== src/rwd_pkg.sv ====
package rwd_pkg;
	// ****************************************************
	// clock and timing
	// ****************************************************
	localparam int CLK_HZ = 25_000_000;
	localparam int TOUT_BASE_US = 4100;
	localparam int TOUT_BASE_CYC = TOUT_BASE_US * (CLK_HZ / 1_000_000);
	localparam int CHANGE_WINDOW_CYC = 4;
	localparam logic [2:0] WINDOW_LOAD = 3'(CHANGE_WINDOW_CYC);
	localparam int WDT_BASE_OSC = 2048;
	localparam logic [3:0] WDT_PS_MAX = 4'h9;

	// ****************************************************
	// register map
	// ****************************************************
	localparam logic [11:0] ADDR_RESET_CAUSE = 12'h054;
	localparam logic [11:0] ADDR_WDT_CTRL = 12'h060;

	// reset_cause_register fields
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_EXT = 1;
	localparam int CAUSE_BOD = 2;
	localparam int CAUSE_WDT = 3;
	localparam int CAUSE_TEST = 4;
	localparam int CAUSE_W = 5;
	localparam logic [4:0] CAUSE_RST = 5'h00;

	// watchdog_control_register fields
	localparam int CTRL_IF = 7;
	localparam int CTRL_IE = 6;
	localparam int CTRL_PS3 = 5;
	localparam int CTRL_CE = 4;
	localparam int CTRL_RE = 3;
	localparam int CTRL_PS_LO = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;

	typedef enum logic [1:0] {
		RS_HOLD,
		RS_DELAY,
		RS_RUN
	} rwd_rst_state_t;
endpackage

// ==== src/rwd_sync.sv ====
`timescale 1ns/1ps
module rwd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_ff <= RST_VAL;
			q_ff <= RST_VAL;
		end else begin
			meta_ff <= d_i;
			q_ff <= meta_ff;
		end
	end

	assign q_o = q_ff;
endmodule // rwd_sync

// ==== verification/rwd_far_side.sv ====
`timescale 1ns/1ps
// ****
// software kicks, reset pin and watchdog oscillator
// ****
module rwd_far_side (
	input wire logic clk_i,
	input wire logic pin_low_i,
	input wire logic kick_en_i,
	output logic pin_n_o,
	output logic osc_o,
	output logic restart_o
);
	logic [3:0] kick_cnt_ff = 4'h0;
	initial osc_o = 1'b0;
	// scaled oscillator, free running, phase unrelated to the system clock
	always #210 osc_o = ~osc_o;
	// pin has a pull-up: released reads high
	assign pin_n_o = ~pin_low_i;
	always_ff @(posedge clk_i) begin
		kick_cnt_ff <= kick_cnt_ff + 4'h1;
	end
	// kick every 16 cycles, well inside the shortest scaled timeout
	assign restart_o = kick_en_i && kick_cnt_ff == 4'h0;
endmodule // rwd_far_side

// ==== verification/reset_and_watchdog_control_tb_top.sv ====
`timescale 1ns/1ps
module reset_and_watchdog_control_tb_top;
	import rwd_pkg::*;
	// ****
	// short counts keep the run brief
	// ****
	localparam int DLY = 8;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic por = 1'b0, pin_low = 1'b0, brownout_detector = 1'b0, bod_en = 1'b0, tst = 1'b0;
	logic pin_dis = 1'b0, aon = 1'b0, ack = 1'b0, kick_en = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] stf = 2'h0;
	logic [3:0] cks = 4'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic hready, hresp, io_n, sys_n, irq, pulse, pin_n, osc, restart;
	int fail_count = 0;
	int samples_checked = 0;
	int n;
	always #20 mclk = ~mclk;

	rwd_top #(.DELAY_BASE_CYC(DLY), .WDT_BASE(4)) u_rwd_top (
		.MCLK_I(mclk), .RST_N_I(rst_n), .POR_LOW_I(por), .RESET_PIN_N_I(pin_n),
		.BOD_LOW_I(brownout_detector), .BOD_ENABLE_I(bod_en), .TEST_RESET_I(tst),
		.RESET_PIN_DISABLE_FUSE_I(pin_dis), .WATCHDOG_ALWAYS_ON_FUSE_I(aon),
		.STARTUP_TIME_FUSE_I(stf), .CLOCK_SOURCE_FUSE_I(cks), .WDT_OSC_I(osc),
		.WDT_RESTART_I(restart), .WDT_IRQ_ACK_I(ack), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.IO_RESET_N_O(io_n), .SYS_RESET_N_O(sys_n), .WDT_IRQ_O(irq),
		.WDT_RESET_PULSE_O(pulse)
	);
	rwd_far_side u_rwd_far_side (.clk_i(mclk), .pin_low_i(pin_low), .kick_en_i(kick_en),
		.pin_n_o(pin_n), .osc_o(osc), .restart_o(restart));

	// ****
	// shared tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask

	// entered just after a rising edge; ready is read at the falling edge, mid-cycle
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		logic rdy;
		logic [31:0] dat;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		do begin
			@(negedge mclk);
			rdy = hready;
			@(posedge mclk);
		end while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(negedge mclk);
			rdy = hready;
			dat = hrdata;
			@(posedge mclk);
		end while (rdy !== 1'b1);
		rd = dat;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return irq;
			1: return pulse;
			2: return restart;
			default: return sys_n;
		endcase
	endfunction

	// returns on the falling edge where the signal is seen high
	task automatic wait_hi(input int s, output int k);
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (sig(s) !== 1'b1 && k < 400);
		check({31'h0, sig(s)}, 32'h1);
	endtask

	task automatic wait_sys(input int lo);
		wait_hi(3, n);
		@(posedge mclk);
		check({31'h0, n >= lo && n <= lo + 6}, 32'h1);
	endtask

	task automatic src(input int i, input logic v);
		case (i)
			0: pin_low <= v;
			1: brownout_detector <= v;
			default: tst <= v;
		endcase
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset;
		wait_sys(DLY);
		rd_chk(ADDR_WDT_CTRL, 32'h0);
		rd_chk(ADDR_RESET_CAUSE, 32'h0);
		rd_chk(12'h058, 32'h0);
		check({31'h0, hresp}, 32'h0);
	endtask

	task automatic t_sources;
		logic [31:0] exp;
		exp = 32'h0;
		bod_en <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			stf <= 2'(i);
			src(i, 1'b1);
			@(negedge mclk);
			check({31'h0, io_n}, 32'h0);
			cyc(5);
			check({31'h0, sys_n}, 32'h0);
			src(i, 1'b0);
			// reassert while the stretch is still counting
			cyc(5);
			src(i, 1'b1);
			cyc(4);
			src(i, 1'b0);
			wait_sys(DLY << i);
			exp[i == 0 ? CAUSE_EXT : (i == 1 ? CAUSE_BOD : CAUSE_TEST)] = 1'b1;
			rd_chk(ADDR_RESET_CAUSE, exp);
		end
		stf <= 2'h0;
		bus(1'b1, ADDR_RESET_CAUSE, 32'h0);
		rd_chk(ADDR_RESET_CAUSE, 32'h0);
	endtask

	task automatic t_masked;
		pin_dis <= 1'b1;
		bod_en <= 1'b0;
		pin_low <= 1'b1;
		brownout_detector <= 1'b1;
		cyc(6);
		check({31'h0, sys_n}, 32'h1);
		pin_low <= 1'b0;
		brownout_detector <= 1'b0;
		cyc(3);
		pin_dis <= 1'b0;
	endtask

	task automatic t_prescale;
		kick_en <= 1'b1;
		bus(1'b1, ADDR_WDT_CTRL, 32'h08);
		bus(1'b1, ADDR_WDT_CTRL, 32'h00);
		rd_chk(ADDR_WDT_CTRL, 32'h08);
		bus(1'b1, ADDR_WDT_CTRL, 32'h18);
		cyc(6);
		bus(1'b1, ADDR_WDT_CTRL, 32'h01);
		rd_chk(ADDR_WDT_CTRL, 32'h08);
		bus(1'b1, ADDR_WDT_CTRL, 32'h18);
		bus(1'b1, ADDR_WDT_CTRL, 32'h01);
		rd_chk(ADDR_WDT_CTRL, 32'h01);
		wait_hi(2, n);
		@(posedge mclk);
		kick_en <= 1'b0;
		bus(1'b1, ADDR_WDT_CTRL, 32'h41);
		wait_hi(0, n);
		// code 1 gives eight ticks, about 84 cycles
		check({31'h0, n >= 66 && n <= 100}, 32'h1);
		@(posedge mclk);
		ack <= 1'b1;
		@(posedge mclk);
		ack <= 1'b0;
		bus(1'b1, ADDR_WDT_CTRL, 32'h01);
		rd_chk(ADDR_WDT_CTRL, 32'h01);
		check({30'h0, irq, sys_n}, 32'h1);
	endtask

	task automatic t_combined;
		bus(1'b1, ADDR_WDT_CTRL, 32'h48);
		wait_hi(0, n);
		@(posedge mclk);
		rd_chk(ADDR_WDT_CTRL, 32'h89);
		bus(1'b1, ADDR_WDT_CTRL, 32'h89);
		wait_hi(1, n);
		check({30'h0, io_n, sys_n}, 32'h1);
		@(negedge mclk);
		check({30'h0, pulse, sys_n}, 32'h0);
		@(posedge mclk);
		kick_en <= 1'b1;
		wait_sys(DLY);
		rd_chk(ADDR_RESET_CAUSE, 32'h08);
		rd_chk(ADDR_WDT_CTRL, 32'h08);
		n = 0;
		repeat (150) begin
			@(negedge mclk);
			if (pulse === 1'b1) begin
				n++;
			end
		end
		@(posedge mclk);
		check(32'(n), 32'h0);
		bus(1'b1, ADDR_WDT_CTRL, 32'h18);
		bus(1'b1, ADDR_WDT_CTRL, 32'h00);
		rd_chk(ADDR_WDT_CTRL, 32'h08);
		bus(1'b1, ADDR_RESET_CAUSE, 32'h00);
		bus(1'b1, ADDR_WDT_CTRL, 32'h18);
		bus(1'b1, ADDR_WDT_CTRL, 32'h00);
		rd_chk(ADDR_WDT_CTRL, 32'h00);
	endtask

	task automatic t_fuse_por;
		aon <= 1'b1;
		cks <= 4'h1;
		bus(1'b1, ADDR_WDT_CTRL, 32'h40);
		rd_chk(ADDR_WDT_CTRL, 32'h08);
		tst <= 1'b1;
		cyc(4);
		por <= 1'b1;
		@(negedge mclk);
		check({31'h0, io_n}, 32'h0);
		@(posedge mclk);
		tst <= 1'b0;
		cyc(4);
		por <= 1'b0;
		aon <= 1'b0;
		wait_sys(DLY << 1);
		rd_chk(ADDR_RESET_CAUSE, 32'h01);
		rd_chk(ADDR_WDT_CTRL, 32'h00);
	endtask

	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_sources();
		t_masked();
		t_prescale();
		t_combined();
		t_fuse_por();
		report_and_stop();
	end

	// the whole sequence needs under 3000 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		report_and_stop();
	end
endmodule // reset_and_watchdog_control_tb_top
